// *** core/ilc_immediate_alu_map.vh ***
// Opcode encodings, operation codes and state counts for the immediate ALU.
`ifndef ILC_IMMEDIATE_ALU_MAP_VH
`define ILC_IMMEDIATE_ALU_MAP_VH

// First bytes of the accumulator forms and the two prefix bytes.
`define ILC_OPC_AND_ACC 8'h07
`define ILC_OPC_OR_ACC 8'h17
`define ILC_OPC_XOR_ACC 8'h16
`define ILC_OPC_GT_ACC 8'h27
`define ILC_OPC_LT_ACC 8'h37
`define ILC_PFX_GEN 8'h74
`define ILC_PFX_SPEC 8'h64

// Operation field of the second byte, shared by general and special forms.
`define ILC_FN_AND 4'h1
`define ILC_FN_XOR 4'h2
`define ILC_FN_OR 4'h3
`define ILC_FN_GT 4'h5
`define ILC_FN_LT 4'h7

// Internal operation codes.
`define ILC_OP_AND 3'h0
`define ILC_OP_OR 3'h1
`define ILC_OP_XOR 3'h2
`define ILC_OP_GT 3'h3
`define ILC_OP_LT 3'h4

// Operand targets.
`define ILC_TGT_ACC 2'h0
`define ILC_TGT_GEN 2'h1
`define ILC_TGT_SPEC 2'h2

// Index of the accumulator among the general registers.
`define ILC_ACC_INDEX 3'h1

// State counts, executed and skipped.
`define ILC_ST_ACC 5'h07
`define ILC_ST_GEN 5'h0b
`define ILC_ST_SPEC_LOGIC 5'h14
`define ILC_ST_SPEC_CMP 5'h0e
`define ILC_ST_SKIP_2B 5'h07
`define ILC_ST_SKIP_3B 5'h0b

`endif

// *** core/ilc_immediate_alu.v ***
// Immediate logic and compare execution datapath with its register files.
`timescale 1ns/1ns
`default_nettype none
`include "ilc_immediate_alu_map.vh"

// Overview of operation
// RULE1 - 3-bit selector picks V,A,B,C,D,E,H,L
// RULE2 - 4-bit special selector, only listed codes valid
// RULE3 - AND general register with byte three, 11 states
// RULE4 - AND special register with byte three, 20 states
// RULE5 - OR accumulator with byte two, 7 states
// RULE6 - OR general 11 states, special 20 states
// RULE7 - XOR accumulator, general or special register
// RULE8 - Logic ops: zero from result, clear skip, chain
// RULE9 - Accumulator greater-than: A-byte-1, skip if no borrow
// RULE10 - Register greater-than, general 11, special 14 states
// RULE11 - Accumulator less-than: skip when borrow, 7 states
// RULE12 - General less-than: skip on borrow, 11 states
// RULE13 - Compares update zero, skip, half-carry, carry
// RULE14 - Decode prefixes 74h and 64h with operation field
// RULE15 - AND accumulator with byte two, same flags
// RULE16 - Skipped instruction costs the parenthesised count
module ilc_immediate_alu (
  input wire clk,
  input wire arst_n,
  input wire instValid,
  input wire [7:0] instByte1,
  input wire [7:0] instByte2,
  input wire [7:0] instByte3,
  input wire rdSpecial,
  input wire [3:0] rdSel,
  output reg busy,
  output reg done,
  output reg illegalOp,
  output reg [7:0] rdData,
  output reg zeroFlag,
  output reg branchOverFlag,
  output reg halfCarryFlag,
  output reg carryFlag,
  output reg chainedLoadFlagOne,
  output reg chainedLoadFlagZero
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state;
  reg [4:0] cnt;
  reg [7:0] gpr [0:7];
  reg [7:0] spr [0:15];
  reg pendWrite;
  reg pendSkipped;
  reg pendCompare;
  reg [1:0] pendTarget;
  reg [3:0] pendSel;
  reg [7:0] pendData;
  reg pendZero;
  reg pendSkipCond;
  reg pendHalf;
  reg pendCarry;

  reg decOk;
  reg [2:0] decOp;
  reg [1:0] decTarget;
  reg [3:0] decSel;
  reg [7:0] operand;
  reg [7:0] imm;
  reg [7:0] logicRes;
  reg [9:0] subRes;
  reg [4:0] decStates;
  integer i;

  //////////////////////////////////////////////////////////////////////////
  // Special selector codes that name a register.
  function specValid;
    input [3:0] code;
    begin
      case (code)
        4'h4, 4'ha, 4'hc, 4'he, 4'hf: specValid = 1'b0;
        default: specValid = 1'b1;
      endcase
    end
  endfunction

  // Returns {halfBorrow, borrow, difference} of a - b - extra.
  function [9:0] cmpSub;
    input [7:0] a;
    input [7:0] b;
    input extra;
    reg [8:0] full;
    reg [4:0] low;
    begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, extra};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, extra};
      cmpSub = {low[4], full[8], full[7:0]};
    end
  endfunction

  // Maps the second-byte operation field onto an internal operation.
  function [3:0] fnDecode;
    input [3:0] fn;
    begin
      case (fn)
        `ILC_FN_AND: fnDecode = {1'b1, `ILC_OP_AND};
        `ILC_FN_OR: fnDecode = {1'b1, `ILC_OP_OR};
        `ILC_FN_XOR: fnDecode = {1'b1, `ILC_OP_XOR};
        `ILC_FN_GT: fnDecode = {1'b1, `ILC_OP_GT};
        `ILC_FN_LT: fnDecode = {1'b1, `ILC_OP_LT};
        default: fnDecode = 4'h0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Instruction decode and operand fetch.
  always @* begin
    decOk = 1'b0;
    decOp = `ILC_OP_AND;
    decTarget = `ILC_TGT_ACC;
    decSel = {1'b0, `ILC_ACC_INDEX};
    imm = instByte2;
    case (instByte1)
      `ILC_OPC_AND_ACC: begin
        decOk = 1'b1; // [RULE15]
        decOp = `ILC_OP_AND;
      end
      `ILC_OPC_OR_ACC: begin
        decOk = 1'b1; // [RULE5]
        decOp = `ILC_OP_OR;
      end
      `ILC_OPC_XOR_ACC: begin
        decOk = 1'b1; // [RULE7]
        decOp = `ILC_OP_XOR;
      end
      `ILC_OPC_GT_ACC: begin
        decOk = 1'b1; // [RULE9]
        decOp = `ILC_OP_GT;
      end
      `ILC_OPC_LT_ACC: begin
        decOk = 1'b1; // [RULE11]
        decOp = `ILC_OP_LT;
      end
      `ILC_PFX_GEN: begin
        {decOk, decOp} = instByte2[7] ? 4'h0
          : fnDecode(instByte2[6:3]); // [RULE14]
        decTarget = `ILC_TGT_GEN;
        decSel = {1'b0, instByte2[2:0]}; // [RULE1]
        imm = instByte3;
      end
      `ILC_PFX_SPEC: begin
        {decOk, decOp} = fnDecode(instByte2[6:3]); // [RULE14]
        decTarget = `ILC_TGT_SPEC;
        decSel = {instByte2[7], instByte2[2:0]};
        decOk = decOk & specValid(decSel); // [RULE2]
        imm = instByte3;
      end
      default: decOk = 1'b0;
    endcase
    if (decTarget == `ILC_TGT_SPEC) begin
      operand = spr[decSel];
    end else begin
      operand = gpr[decSel[2:0]];
    end
    case (decOp)
      `ILC_OP_OR: logicRes = operand | imm;
      `ILC_OP_XOR: logicRes = operand ^ imm;
      default: logicRes = operand & imm;
    endcase
    subRes = cmpSub(operand, imm, decOp == `ILC_OP_GT); // [RULE9] [RULE10]
    if (decTarget == `ILC_TGT_ACC) begin
      decStates = `ILC_ST_ACC;
    end else if (decTarget == `ILC_TGT_GEN) begin
      decStates = `ILC_ST_GEN; // [RULE3] [RULE6] [RULE12]
    end else if (decOp == `ILC_OP_GT || decOp == `ILC_OP_LT) begin
      decStates = `ILC_ST_SPEC_CMP; // [RULE10]
    end else begin
      decStates = `ILC_ST_SPEC_LOGIC; // [RULE4] [RULE6]
    end
    if (branchOverFlag) begin
      decStates = (decTarget == `ILC_TGT_ACC) ? `ILC_ST_SKIP_2B
        : `ILC_ST_SKIP_3B; // [RULE16]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer, register files and flags.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
      illegalOp <= 1'b0;
      rdData <= 8'h00;
      zeroFlag <= 1'b0;
      branchOverFlag <= 1'b0;
      halfCarryFlag <= 1'b0;
      carryFlag <= 1'b0;
      chainedLoadFlagOne <= 1'b0;
      chainedLoadFlagZero <= 1'b0;
      pendWrite <= 1'b0;
      pendSkipped <= 1'b0;
      pendCompare <= 1'b0;
      pendTarget <= `ILC_TGT_ACC;
      pendSel <= 4'h0;
      pendData <= 8'h00;
      pendZero <= 1'b0;
      pendSkipCond <= 1'b0;
      pendHalf <= 1'b0;
      pendCarry <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        gpr[i] <= 8'h00;
      end
      for (i = 0; i < 16; i = i + 1) begin
        spr[i] <= 8'h00;
      end
    end else begin
      done <= 1'b0;
      illegalOp <= 1'b0;
      rdData <= rdSpecial ? spr[rdSel] : gpr[rdSel[2:0]];
      case (state)
        ST_IDLE: begin
          if (instValid && !decOk) begin
            illegalOp <= 1'b1;
          end else if (instValid) begin
            state <= ST_EXEC;
            busy <= 1'b1;
            cnt <= decStates - 5'h01;
            pendSkipped <= branchOverFlag; // [RULE16]
            pendCompare <= (decOp == `ILC_OP_GT) || (decOp == `ILC_OP_LT);
            pendWrite <= (decOp != `ILC_OP_GT) && (decOp != `ILC_OP_LT);
            pendTarget <= decTarget;
            pendSel <= decSel;
            pendData <= logicRes;
            pendZero <= (decOp == `ILC_OP_GT || decOp == `ILC_OP_LT)
              ? (subRes[7:0] == 8'h00) : (logicRes == 8'h00);
            pendSkipCond <= (decOp == `ILC_OP_LT) ? subRes[8]
              : !subRes[8]; // [RULE9] [RULE10] [RULE11] [RULE12]
            pendHalf <= subRes[9];
            pendCarry <= subRes[8];
          end
        end
        ST_EXEC: begin
          if (cnt == 5'h01) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            if (pendSkipped) begin
              branchOverFlag <= 1'b0; // [RULE16]
            end else if (pendCompare) begin
              zeroFlag <= pendZero; // [RULE13]
              branchOverFlag <= pendSkipCond;
              halfCarryFlag <= pendHalf;
              carryFlag <= pendCarry;
              chainedLoadFlagOne <= 1'b0;
              chainedLoadFlagZero <= 1'b0;
            end else begin
              zeroFlag <= pendZero; // [RULE8]
              branchOverFlag <= 1'b0;
              chainedLoadFlagOne <= 1'b0;
              chainedLoadFlagZero <= 1'b0;
              if (pendWrite && pendTarget == `ILC_TGT_SPEC) begin
                spr[pendSel] <= pendData; // [RULE4] [RULE6] [RULE7]
              end else if (pendWrite) begin
                gpr[pendSel[2:0]] <= pendData; // [RULE3] [RULE5] [RULE7]
              end
            end
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** test/ilc_immediate_alu_checker.sv ***
// Concurrent checks on the ports of the immediate ALU.
`timescale 1ns/1ns
`default_nettype none
`include "ilc_immediate_alu_map.vh"
module ilc_immediate_alu_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instValid,
  input wire logic [7:0] instByte1,
  input wire logic [7:0] instByte2,
  input wire logic busy,
  input wire logic done,
  input wire logic illegalOp,
  input wire logic zeroFlag,
  input wire logic branchOverFlag,
  input wire logic carryFlag,
  input wire logic chainedLoadFlagOne,
  input wire logic chainedLoadFlagZero
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic take = !busy && instValid;
  wire logic [3:0] fn = instByte2[6:3];
  wire logic spec = take && instByte1 == `ILC_PFX_SPEC;
  wire logic specD = spec && {instByte2[7], instByte2[2:0]} == 4'hd;
  wire logic fnOk = fn == 1 || fn == 2 || fn == 3 || fn == 5 || fn == 7;
  done_pulse_a: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  acc_len_a: assert property (take && instByte1 == `ILC_OPC_OR_ACC
    |=> busy[*6] ##1 (done && !busy)) else $error("accumulator form length");
  gen_len_a: assert property (take && instByte1 == `ILC_PFX_GEN &&
    !instByte2[7] && fnOk |=> busy ##10 done) else $error("general length");
  spec_logic_a: assert property (specD && fn != 0 && fn <= 3 &&
    !branchOverFlag |-> ##20 done) else $error("special logic length");
  spec_cmp_a: assert property (specD && (fn == 5 || fn == 7) &&
    !branchOverFlag |-> ##14 done) else $error("special compare length");
  bad_op_a: assert property (take && instByte1 == 8'hff |=>
    illegalOp && !busy) else $error("undecodable opcode accepted");
  ill_pulse_a: assert property (illegalOp |=> !illegalOp)
    else $error("illegal pulse too long");
  chain_clr_a: assert property (done |->
    !chainedLoadFlagOne && !chainedLoadFlagZero) else $error("chain set");
  flag_hold_a: assert property ($changed(zeroFlag) ||
    $changed(carryFlag) |-> done) else $error("flag moved outside commit");
  cover property (take && instByte1 == `ILC_OPC_GT_ACC);
  cover property (specD && fn == 5);
  cover property (done && branchOverFlag);
endmodule
`default_nettype wire

// *** test/tb_ilc_immediate_alu.sv ***
// Self-checking bench for the immediate ALU.
`timescale 1ns/1ns
`default_nettype none
`include "ilc_immediate_alu_map.vh"
module tb_ilc_immediate_alu;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instValid = 1'b0;
  logic [7:0] instByte1 = 8'h00;
  logic [7:0] instByte2 = 8'h00;
  logic [7:0] instByte3 = 8'h00;
  logic rdSpecial = 1'b0;
  logic [3:0] rdSel = 4'h0;
  wire logic busy, done, illegalOp;
  wire logic [7:0] rdData;
  wire logic [5:0] flags;
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  ilc_immediate_alu u_ilc_immediate_alu (.clk(clk), .arst_n(arst_n),
    .instValid(instValid), .instByte1(instByte1), .instByte2(instByte2),
    .instByte3(instByte3), .rdSpecial(rdSpecial), .rdSel(rdSel),
    .busy(busy), .done(done), .illegalOp(illegalOp), .rdData(rdData),
    .zeroFlag(flags[5]), .branchOverFlag(flags[4]),
    .halfCarryFlag(flags[3]), .carryFlag(flags[2]),
    .chainedLoadFlagOne(flags[1]), .chainedLoadFlagZero(flags[0]));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failCount++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Issues one instruction, then checks its length and the flags.
  task automatic exec(input logic [7:0] b1, b2, b3, input int n,
                      input logic [5:0] f);
    int cnt;
    instValid = 1'b1;
    instByte1 = b1;
    instByte2 = b2;
    instByte3 = b3;
    @(negedge clk);
    instValid = 1'b0;
    cnt = 1;
    while (done !== 1'b1 && cnt < 40) begin
      @(negedge clk);
      cnt++;
    end
    check(8'(cnt), 8'(n));
    check({2'h0, flags}, {2'h0, f});
  endtask
  task automatic rd(input logic sp, input logic [3:0] sel,
                    input logic [7:0] exp);
    rdSpecial = sp;
    rdSel = sel;
    @(negedge clk);
    check(rdData, exp);
  endtask
  task automatic bad(input logic [7:0] b1, b2);
    instValid = 1'b1;
    instByte1 = b1;
    instByte2 = b2;
    @(negedge clk);
    instValid = 1'b0;
    check({6'h0, illegalOp, busy}, 8'h02);
    @(negedge clk);
    check({6'h0, illegalOp, busy}, 8'h00);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    exec(`ILC_OPC_OR_ACC, 8'h55, 8'h00, 7, 6'h00);
    rd(1'b0, 4'h1, 8'h55);
    exec(`ILC_PFX_GEN, 8'h12, 8'h0f, 11, 6'h00);
    exec(`ILC_PFX_GEN, 8'h0a, 8'h03, 11, 6'h00);
    rd(1'b0, 4'h2, 8'h03);
    exec(`ILC_PFX_SPEC, 8'h9d, 8'h80, 20, 6'h00);
    rd(1'b1, 4'hd, 8'h80);
    exec(`ILC_OPC_GT_ACC, 8'h05, 8'h00, 7, 6'h18);
    exec(`ILC_OPC_XOR_ACC, 8'hff, 8'h00, 7, 6'h08);
    rd(1'b0, 4'h1, 8'h55);
    exec(`ILC_PFX_GEN, 8'h3a, 8'h04, 11, 6'h1c);
    exec(`ILC_PFX_GEN, 8'h0a, 8'h00, 11, 6'h0c);
    rd(1'b0, 4'h2, 8'h03);
    exec(`ILC_PFX_GEN, 8'h18, 8'h00, 11, 6'h2c);
    exec(`ILC_PFX_SPEC, 8'had, 8'h7f, 14, 6'h38);
    exec(`ILC_OPC_AND_ACC, 8'h00, 8'h00, 7, 6'h28);
    exec(`ILC_OPC_XOR_ACC, 8'h55, 8'h00, 7, 6'h28);
    rd(1'b0, 4'h1, 8'h00);
    exec(`ILC_OPC_AND_ACC, 8'hff, 8'h00, 7, 6'h28);
    exec(`ILC_OPC_LT_ACC, 8'h01, 8'h00, 7, 6'h1c);
    bad(8'hff, 8'h00);
    bad(`ILC_PFX_SPEC, 8'h0c);
    conclude();
  end
endmodule
bind ilc_immediate_alu ilc_immediate_alu_checker u_ilc_immediate_alu_checker (
  .clk(clk), .arst_n(arst_n), .instValid(instValid),
  .instByte1(instByte1), .instByte2(instByte2), .busy(busy),
  .done(done), .illegalOp(illegalOp), .zeroFlag(zeroFlag),
  .branchOverFlag(branchOverFlag), .carryFlag(carryFlag),
  .chainedLoadFlagOne(chainedLoadFlagOne),
  .chainedLoadFlagZero(chainedLoadFlagZero));
`default_nettype wire
